// ### sdr_regs.sv
// status and diagnostic register bank of the battery monitor
// ------------------------------------------------------------------
// Summary of operation
// - sync codes 0x01..0x11 select cells 1..17
// - bit 10 enables switch driver check
// - bits 9:8 pick switch on/off check
// - bit 6 enables fast current diagnosis
// - bit 5 enables slow current diagnosis
// - bit 0 enables open wire detection
// - status 15:13 pin levels, gated by enable
// - status 11/10 show discharge/charge switch on
// - status 9/8 show high voltage outputs low
// - slow conversion done flag, write one clears
// - fast conversion done flag, write one clears
// - voltage conversion done flag, write one clears
// - status 4:0 show present operating mode
// - second status shows cells 16..1 measuring
// - sync selection acts only while enabled
// ------------------------------------------------------------------
module sdr_regs (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [sdr_pkg::WORD_W-1:0] reg_wdata,
   input wire logic [2:0] gpio_pin,
   input wire logic [2:0] pin_input_enable,
   input wire logic discharge_switch_state,
   input wire logic charge_switch_state,
   input wire logic [1:0] hv_output_state,
   input wire logic slow_current_done_evt,
   input wire logic fast_current_done_evt,
   input wire logic voltage_conv_done_evt,
   input wire logic [4:0] mode_flags,
   input wire logic [15:0] cell_measure_on,
   input wire logic sync_measure_enable,
   output logic [4:0] sync_cell_selector_ff,
   output logic [4:0] sync_cell_target_ff,
   output logic switch_diag_enable_ff,
   output logic [1:0] switch_check_selector_ff,
   output logic fast_current_diag_enable_ff,
   output logic slow_current_diag_enable_ff,
   output logic open_wire_detect_enable_ff,
   output logic [sdr_pkg::WORD_W-1:0] reg_rdata_ff
);
   import sdr_pkg::*;

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   logic [2:0] pin_meta_ff, pin_sync_ff, pin_level_ff;
   logic [2:0] nxt_pin_level;
   logic [1:0] switch_st_ff, nxt_switch_st;
   logic [1:0] hv_st_ff, nxt_hv_st;
   logic [4:0] mode_ff, nxt_mode;
   logic [15:0] cells_ff, nxt_cells;
   logic [2:0] done_ff, nxt_done;
   logic [2:0] done_evt;
   logic [4:0] nxt_sync_sel, nxt_sync_target;
   logic nxt_sw_en, nxt_fast_en, nxt_slow_en, nxt_open_en;
   logic [1:0] nxt_sw_sel;
   logic [15:0] nxt_rdata, diag_word, primary_status_word_word;
   logic wr_diag, wr_primary_status_word, sel_legal;

   assign wr_diag = reg_wr && (reg_addr == ADDR_DIAG_CTRL);
   assign wr_primary_status_word = reg_wr && (reg_addr == ADDR_STAT_PRIMARY);
   // done bits in status order 7:5 = slow, fast, voltage
   assign done_evt = {slow_current_done_evt, fast_current_done_evt,
                      voltage_conv_done_evt};

   // ---------------------------------------------------------------
   // pin synchroniser, pins are asynchronous to clk
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_meta_ff <= 3'h0;
         pin_sync_ff <= 3'h0;
      end else begin
         pin_meta_ff <= gpio_pin;
         pin_sync_ff <= pin_meta_ff;
      end
   end

   // ---------------------------------------------------------------
   // status capture
   // ---------------------------------------------------------------
   always_comb begin
      // level means nothing with the input buffer off, so read zero
      nxt_pin_level = pin_sync_ff & pin_input_enable;
      nxt_switch_st = {discharge_switch_state, charge_switch_state};
      nxt_hv_st = hv_output_state;
      nxt_mode = mode_flags;
      nxt_cells = cell_measure_on;
      // set is or'ed in last so a completion is never lost
      nxt_done = done_ff;
      if (wr_primary_status_word) begin
         nxt_done = done_ff & ~reg_wdata[DONE_LSB+2:DONE_LSB];
      end
      nxt_done = nxt_done | done_evt;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_level_ff <= 3'h0;
         switch_st_ff <= 2'h0;
         hv_st_ff <= 2'h0;
         mode_ff <= 5'h00;
         cells_ff <= WORD_RESET;
         done_ff <= 3'h0;
      end else begin
         pin_level_ff <= nxt_pin_level;
         switch_st_ff <= nxt_switch_st;
         hv_st_ff <= nxt_hv_st;
         mode_ff <= nxt_mode;
         cells_ff <= nxt_cells;
         done_ff <= nxt_done;
      end
   end

   // ---------------------------------------------------------------
   // diagnostic control word
   // ---------------------------------------------------------------
   always_comb begin
      nxt_sync_sel = sync_cell_selector_ff;
      nxt_sw_en = switch_diag_enable_ff;
      nxt_sw_sel = switch_check_selector_ff;
      nxt_fast_en = fast_current_diag_enable_ff;
      nxt_slow_en = slow_current_diag_enable_ff;
      nxt_open_en = open_wire_detect_enable_ff;
      if (wr_diag) begin
         nxt_sync_sel = reg_wdata[SYNC_SEL_MSB:SYNC_SEL_LSB];
         nxt_sw_en = reg_wdata[SW_DIAG_EN_BIT];
         nxt_sw_sel = reg_wdata[SW_CHECK_MSB:SW_CHECK_LSB];
         nxt_fast_en = reg_wdata[FAST_DIAG_BIT];
         nxt_slow_en = reg_wdata[SLOW_DIAG_BIT];
         nxt_open_en = reg_wdata[OPEN_WIRE_BIT];
      end
      // a forbidden code pairs no cell rather than a random one
      sel_legal = (sync_cell_selector_ff >= SYNC_SEL_FIRST) &&
                  (sync_cell_selector_ff <= SYNC_SEL_LAST);
      nxt_sync_target = SYNC_SEL_NONE;
      if (sync_measure_enable && sel_legal) begin
         nxt_sync_target = sync_cell_selector_ff;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync_cell_selector_ff <= SYNC_SEL_NONE;
         sync_cell_target_ff <= SYNC_SEL_NONE;
         switch_diag_enable_ff <= 1'b0;
         switch_check_selector_ff <= SW_CHECK_RESET;
         fast_current_diag_enable_ff <= 1'b0;
         slow_current_diag_enable_ff <= 1'b0;
         open_wire_detect_enable_ff <= 1'b0;
      end else begin
         sync_cell_selector_ff <= nxt_sync_sel;
         sync_cell_target_ff <= nxt_sync_target;
         switch_diag_enable_ff <= nxt_sw_en;
         switch_check_selector_ff <= nxt_sw_sel;
         fast_current_diag_enable_ff <= nxt_fast_en;
         slow_current_diag_enable_ff <= nxt_slow_en;
         open_wire_detect_enable_ff <= nxt_open_en;
      end
   end

   // ---------------------------------------------------------------
   // read path, one cycle latency
   // ---------------------------------------------------------------
   always_comb begin
      diag_word = WORD_RESET;
      diag_word[SYNC_SEL_MSB:SYNC_SEL_LSB] = sync_cell_selector_ff;
      diag_word[SW_DIAG_EN_BIT] = switch_diag_enable_ff;
      diag_word[SW_CHECK_MSB:SW_CHECK_LSB] = switch_check_selector_ff;
      diag_word[FAST_DIAG_BIT] = fast_current_diag_enable_ff;
      diag_word[SLOW_DIAG_BIT] = slow_current_diag_enable_ff;
      diag_word[OPEN_WIRE_BIT] = open_wire_detect_enable_ff;
      // reserved bit 12 is not stored, so stray host writes vanish
      primary_status_word_word = WORD_RESET;
      primary_status_word_word[PIN_LVL_LSB+2:PIN_LVL_LSB] = pin_level_ff;
      primary_status_word_word[DIS_SW_BIT] = switch_st_ff[1];
      primary_status_word_word[CHG_SW_BIT] = switch_st_ff[0];
      primary_status_word_word[HV_OUT_LSB+1:HV_OUT_LSB] = hv_st_ff;
      primary_status_word_word[DONE_LSB+2:DONE_LSB] = done_ff;
      primary_status_word_word[MODE_LSB+4:MODE_LSB] = mode_ff;
      nxt_rdata = reg_rdata_ff;
      if (reg_rd) begin
         unique case (reg_addr)
            ADDR_DIAG_CTRL: nxt_rdata = diag_word;
            ADDR_STAT_PRIMARY: nxt_rdata = primary_status_word_word;
            ADDR_STAT_CELLS: nxt_rdata = cells_ff;
            default: nxt_rdata = WORD_RESET;
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata_ff <= WORD_RESET;
      end else begin
         reg_rdata_ff <= nxt_rdata;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   property p_sync_off;
      !sync_measure_enable |=> sync_cell_target_ff == SYNC_SEL_NONE;
   endproperty
   a_sync_off: assert property (p_sync_off) else $error("sync not gated");
   property p_sync_map;
      (sync_measure_enable && sync_cell_selector_ff >= SYNC_SEL_FIRST &&
       sync_cell_selector_ff <= SYNC_SEL_LAST)
      |=> sync_cell_target_ff == $past(sync_cell_selector_ff);
   endproperty
   a_sync_map: assert property (p_sync_map) else $error("bad sync cell");
   property p_sw_en;
      wr_diag |=> switch_diag_enable_ff == $past(reg_wdata[SW_DIAG_EN_BIT]);
   endproperty
   a_sw_en: assert property (p_sw_en) else $error("switch diag enable");
   property p_sw_sel;
      wr_diag ##1 !wr_diag |=> switch_check_selector_ff ==
         $past(reg_wdata[SW_CHECK_MSB:SW_CHECK_LSB], 2);
   endproperty
   a_sw_sel: assert property (p_sw_sel) else $error("check select");
   property p_diag_bits;
      wr_diag |=> {fast_current_diag_enable_ff, slow_current_diag_enable_ff,
                   open_wire_detect_enable_ff} ==
         $past({reg_wdata[FAST_DIAG_BIT], reg_wdata[SLOW_DIAG_BIT],
                reg_wdata[OPEN_WIRE_BIT]});
   endproperty
   a_diag_bits: assert property (p_diag_bits) else $error("diag bits");
   property p_pin_gate;
      (reg_rd && reg_addr == ADDR_STAT_PRIMARY && $past(!pin_input_enable[2]))
      |=> !reg_rdata_ff[PIN_LVL_LSB+2];
   endproperty
   a_pin_gate: assert property (p_pin_gate) else $error("pin not gated");
   property p_done_set;
      slow_current_done_evt |=> done_ff[2] [*1] ##0 1;
   endproperty
   a_done_set: assert property (p_done_set) else $error("done lost");
   property p_done_clr;
      (wr_primary_status_word && reg_wdata[DONE_LSB] && !voltage_conv_done_evt)
      |=> !done_ff[0];
   endproperty
   a_done_clr: assert property (p_done_clr) else $error("no clear");
   property p_done_keep;
      (done_ff[1] && !(wr_primary_status_word && reg_wdata[DONE_LSB+1])) |=> done_ff[1];
   endproperty
   a_done_keep: assert property (p_done_keep) else $error("flag lost");
   property p_cells;
      (reg_rd && reg_addr == ADDR_STAT_CELLS) ##1 1
      |-> reg_rdata_ff == $past(cell_measure_on, 2);
   endproperty
   a_cells: assert property (p_cells) else $error("cell status");
   property p_mode;
      (reg_rd && reg_addr == ADDR_STAT_PRIMARY)
      |=> reg_rdata_ff[4:0] == $past(mode_flags, 2);
   endproperty
   a_mode: assert property (p_mode) else $error("mode flags");

   c_clear_race: cover property (wr_primary_status_word && reg_wdata[7] &&
                                 slow_current_done_evt);
   c_sync_run: cover property (sync_cell_target_ff == SYNC_SEL_LAST);
   c_read_stat: cover property (reg_rd && reg_addr == ADDR_STAT_PRIMARY
                                ##1 reg_rdata_ff[6]);
endmodule // sdr_regs

// ### sdr_pkg.sv
// constants for the status and diagnostic register bank
package sdr_pkg;
   // ---------------------------------------------------------------
   // register indices on the serial register port
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_DIAG_CTRL = 8'h1b;
   localparam logic [7:0] ADDR_STAT_PRIMARY = 8'h1c;
   localparam logic [7:0] ADDR_STAT_CELLS = 8'h1d;
   localparam int WORD_W = 16;
   // ---------------------------------------------------------------
   // diagnostic control word fields
   // ---------------------------------------------------------------
   localparam int SYNC_SEL_MSB = 15;
   localparam int SYNC_SEL_LSB = 11;
   localparam int SW_DIAG_EN_BIT = 10;
   localparam int SW_CHECK_MSB = 9;
   localparam int SW_CHECK_LSB = 8;
   localparam int FAST_DIAG_BIT = 6;
   localparam int SLOW_DIAG_BIT = 5;
   localparam int OPEN_WIRE_BIT = 0;
   localparam logic [4:0] SYNC_SEL_FIRST = 5'h01;
   localparam logic [4:0] SYNC_SEL_LAST = 5'h11;
   localparam logic [4:0] SYNC_SEL_NONE = 5'h00;
   localparam logic [1:0] SW_CHECK_RESET = 2'h0;
   // ---------------------------------------------------------------
   // primary status word fields
   // ---------------------------------------------------------------
   localparam int PIN_LVL_LSB = 13;
   localparam int DIS_SW_BIT = 11;
   localparam int CHG_SW_BIT = 10;
   localparam int HV_OUT_LSB = 8;
   localparam int DONE_LSB = 5;
   localparam int MODE_LSB = 0;
   localparam logic [15:0] WORD_RESET = 16'h0000;
endpackage : sdr_pkg

// ### sdr_host.sv
// host model that drives the register port of the status bank
module sdr_host (
   input wire logic clk,
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [sdr_pkg::WORD_W-1:0] reg_wdata,
   input wire logic [sdr_pkg::WORD_W-1:0] reg_rdata_ff
);
   timeunit 1ns;
   timeprecision 100ps;
   import sdr_pkg::*;
   // ---------------------------------------------------------------
   // one-cycle strobes, idle lines toggled so stale data never helps
   // ---------------------------------------------------------------
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 16'h0000;
   end
   task wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= (a == ADDR_STAT_PRIMARY) ? (d & 16'hefff) : d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask
   task rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      // read data stands until the next read, so take it on a clean edge
      @(posedge clk);
      d = reg_rdata_ff;
   endtask
endmodule // sdr_host

// ### status_and_diagnostic_regs_tb_top.sv
// self-checking bench for the status and diagnostic register bank
module status_and_diagnostic_regs_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import sdr_pkg::*;
   logic clk, sys_rst, reg_wr, reg_rd, sync_measure_enable;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata_ff, cell_measure_on, w, d;
   logic [2:0] gpio_pin, pin_input_enable, done_m;
   logic discharge_switch_state, charge_switch_state;
   logic slow_current_done_evt, fast_current_done_evt;
   logic voltage_conv_done_evt, switch_diag_enable_ff;
   logic fast_current_diag_enable_ff, slow_current_diag_enable_ff;
   logic open_wire_detect_enable_ff;
   logic [1:0] hv_output_state, switch_check_selector_ff;
   logic [4:0] mode_flags, sync_cell_selector_ff, sync_cell_target_ff;
   int fail_count, num_checks;
   sdr_regs dut (.clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
      .gpio_pin, .pin_input_enable, .discharge_switch_state,
      .charge_switch_state, .hv_output_state, .slow_current_done_evt,
      .fast_current_done_evt, .voltage_conv_done_evt, .mode_flags,
      .cell_measure_on, .sync_measure_enable, .sync_cell_selector_ff,
      .sync_cell_target_ff, .switch_diag_enable_ff,
      .switch_check_selector_ff, .fast_current_diag_enable_ff,
      .slow_current_diag_enable_ff, .open_wire_detect_enable_ff,
      .reg_rdata_ff);
   sdr_host host (.clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
      .reg_rdata_ff);
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task chk_word(input logic [15:0] g, input logic [15:0] e);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %0t word got %h exp %h", $time, g, e);
      end
   endtask
   task chk_ctl(input logic [10:0] g, input logic [10:0] e);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %0t ctl got %h exp %h", $time, g, e);
      end
   endtask
   function logic [15:0] stat_exp();
      return {gpio_pin & pin_input_enable, 1'b0, discharge_switch_state,
         charge_switch_state, hv_output_state, done_m, mode_flags};
   endfunction
   task pulse_done(input logic [2:0] which);
      @(posedge clk);
      {slow_current_done_evt, fast_current_done_evt,
         voltage_conv_done_evt} <= which;
      @(posedge clk);
      {slow_current_done_evt, fast_current_done_evt,
         voltage_conv_done_evt} <= 3'h0;
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      $display("BAD %0t timeout got %h exp %h", $time, 1'b0, 1'b1);
      finish_test;
   end
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      sys_rst = 1'b1;
      {gpio_pin, pin_input_enable, discharge_switch_state} = 7'h00;
      {charge_switch_state, hv_output_state, mode_flags} = 8'h00;
      {slow_current_done_evt, fast_current_done_evt} = 2'h0;
      {voltage_conv_done_evt, sync_measure_enable} = 2'h0;
      cell_measure_on = 16'h0000;
      {fail_count, num_checks, done_m} = '0;
      w = 16'($urandom(74903));
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      for (int a = 8'h1b; a <= 8'h1d; a++) begin
         host.rd(a[7:0], d);
         chk_word(d, 16'h0000);
      end
      $display("reset test done");
      for (int i = 0; i < 8; i++) begin
         w = 16'($urandom);
         w[15:11] = 5'(1 + $urandom_range(16));
         if (i == 0) w[15:11] = SYNC_SEL_FIRST;
         if (i == 7) w[15:11] = SYNC_SEL_LAST;
         w[9:8] = i[1:0];
         sync_measure_enable <= i[2];
         host.wr(ADDR_DIAG_CTRL, w);
         host.rd(ADDR_DIAG_CTRL, d);
         chk_word(d, w & 16'hff61);
         chk_ctl({sync_cell_selector_ff, switch_diag_enable_ff,
            switch_check_selector_ff, fast_current_diag_enable_ff,
            slow_current_diag_enable_ff, open_wire_detect_enable_ff},
            {w[15:11], w[10], w[9:8], w[6], w[5], w[0]});
         chk_ctl({6'h00, sync_cell_target_ff},
            i[2] ? {6'h00, w[15:11]} : 11'h000);
      end
      $display("diag test done");
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         {gpio_pin, pin_input_enable, discharge_switch_state,
            charge_switch_state, hv_output_state, mode_flags} <= 15'($urandom);
         cell_measure_on <= 16'($urandom);
         repeat (4) @(posedge clk);
         host.rd(ADDR_STAT_PRIMARY, d);
         chk_word(d, stat_exp());
         host.rd(ADDR_STAT_CELLS, d);
         chk_word(d, cell_measure_on);
      end
      // read-only places must shrug off writes
      host.wr(ADDR_STAT_CELLS, 16'hffff);
      host.wr(ADDR_STAT_PRIMARY, 16'hff1f);
      host.wr(8'h00, 16'hffff);
      host.rd(8'h00, d);
      chk_word(d, 16'h0000);
      host.rd(ADDR_STAT_PRIMARY, d);
      chk_word(d, stat_exp());
      host.rd(ADDR_STAT_CELLS, d);
      chk_word(d, cell_measure_on);
      host.rd(ADDR_DIAG_CTRL, d);
      chk_word(d, w & 16'hff61);
      $display("status test done");
      for (int i = 0; i < 3; i++) begin
         pulse_done(3'b100 >> i);
         done_m = 3'b100 >> i;
         host.wr(ADDR_STAT_PRIMARY, 16'h0000);
         host.rd(ADDR_STAT_PRIMARY, d);
         chk_word(d, stat_exp());
         fork
            host.wr(ADDR_STAT_PRIMARY, 16'h0080 >> i);
            pulse_done(3'b100 >> i);
         join
         host.rd(ADDR_STAT_PRIMARY, d);
         chk_word(d, stat_exp());
         host.wr(ADDR_STAT_PRIMARY, 16'h0080 >> i);
         done_m = 3'b000;
         host.rd(ADDR_STAT_PRIMARY, d);
         chk_word(d, stat_exp());
      end
      $display("done flag test done");
      // mid-run reset must wipe set flags and a non-zero control word
      pulse_done(3'b111);
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      host.rd(ADDR_DIAG_CTRL, d);
      chk_word(d, 16'h0000);
      chk_ctl({sync_cell_selector_ff, switch_diag_enable_ff,
         switch_check_selector_ff, fast_current_diag_enable_ff,
         slow_current_diag_enable_ff, open_wire_detect_enable_ff},
         11'h000);
      host.rd(ADDR_STAT_PRIMARY, d);
      chk_word(d, stat_exp());
      $display("reset again test done");
      finish_test;
   end
endmodule // status_and_diagnostic_regs_tb_top
